/* inc/acs_pkg.sv */
package acs_pkg;
    // ---------------------------------------------------------------
    // Register map (byte addresses)
    // ---------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_TIMING = 8'h04;
    localparam logic [7:0] ADDR_RESULT = 8'h08;
    localparam logic [7:0] ADDR_STATUS = 8'h0C;
    localparam logic [7:0] ADDR_ANSEL = 8'h10;
    localparam logic [7:0] ADDR_PORT = 8'h14;
    localparam logic [7:0] ADDR_TRIG = 8'h18;
    // ---------------------------------------------------------------
    // Field positions
    // ---------------------------------------------------------------
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_GO_BIT = 1;
    localparam int TIM_ADCS_LSB = 0;
    localparam int TIM_ACQT_LSB = 3;
    localparam int STAT_DONE_BIT = 0;
    localparam int TRIG_CCP_LSB = 0;
    localparam int TRIG_CTT_BIT = 4;
    // ---------------------------------------------------------------
    // Reset values and timing
    // ---------------------------------------------------------------
    localparam logic [2:0] ACQT_RESET = 3'h0;
    localparam logic [2:0] ADCS_RESET = 3'h0;
    localparam logic [7:0] ANSEL_RESET = 8'hFF;
    localparam logic [3:0] CCP_TRIG_MODE = 4'hB;
    localparam logic [4:0] CONV_TADS = 5'h0E;
    localparam logic [4:0] WAIT_TADS = 5'h02;
    localparam logic [4:0] ACQT_010_TADS = 5'h04;
    localparam logic [6:0] RC_DIV = 7'h28;
    localparam logic [11:0] RESULT_RESET = 12'h000;
    typedef enum logic [1:0]
    {
        ST_SAMPLE = 2'b00,
        ST_ACQ = 2'b01,
        ST_CONV = 2'b10,
        ST_WAIT = 2'b11
    } acs_state_e;
endpackage

/* inc/acs_tad_if.sv */
`timescale 1ns/100ps
interface acs_tad_if;
    logic [2:0] clk_sel;
    logic run;
    logic tick;
    modport gen (input clk_sel, input run, output tick);
    modport seq (output clk_sel, output run, input tick);
endinterface

/* core/acs_tad_gen.sv */
`timescale 1ns/100ps
module acs_tad_gen
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_n_i,
    // Bit period control
    acs_tad_if.gen tad
);
    import acs_pkg::*;
    logic [6:0] cnt_r;
    logic [6:0] cnt_nxt;
    logic [6:0] period;
    logic tick_r;
    logic tick_nxt;

    always_comb
    begin
        unique case (tad.clk_sel)
            3'b000: period = 7'h02;
            3'b100: period = 7'h04;
            3'b001: period = 7'h08;
            3'b101: period = 7'h10;
            3'b010: period = 7'h20;
            3'b110: period = 7'h40;
            default: period = RC_DIV;
        endcase
        cnt_nxt = 7'h00;
        tick_nxt = 1'b0;
        if (tad.run)
        begin
            if (cnt_r + 7'h01 >= period)
                tick_nxt = 1'b1;
            else
                cnt_nxt = cnt_r + 7'h01;
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            cnt_r <= 7'h00;
            tick_r <= 1'b0;
        end
        else
        begin
            cnt_r <= cnt_nxt;
            tick_r <= tick_nxt;
        end
    end
    assign tad.tick = tick_r;
endmodule // acs_tad_gen

/* core/acs_seq.sv */
// The implementer's own choices: the APB register port and the register offsets.
`timescale 1ns/100ps
// What this block does
// - Code 000 starts conversion without delay
// - Nonzero code samples programmed period, then converts
// - Code 010 gives four bit periods
// - No acquisition-done status is exposed
// - Completion clears start, sets done, resamples
// - Conversion lasts fourteen bit periods
// - Clock select maps dividers and RC
// - Holding capacitor disconnected during conversion
// - Zero delay start waits one instruction
// - Clearing start aborts conversion immediately
// - Abort leaves result registers unchanged
// - Two bit periods wait before resampling
// - Enabled triggers set start, begin acquisition
// - Disabled converter: no trigger sets start
// - Compare trigger resets timer regardless
// - Analog pins read zero on port
// - Result loads with start clear, done set
// - Reset disables converter, aborts, restores fields
module acs_seq
#(
    parameter logic [4:0] ACQT_TADS_1 = 5'h02,
    parameter logic [4:0] ACQT_TADS_3 = 5'h06,
    parameter logic [4:0] ACQT_TADS_4 = 5'h08,
    parameter logic [4:0] ACQT_TADS_5 = 5'h0C,
    parameter logic [4:0] ACQT_TADS_6 = 5'h10,
    parameter logic [4:0] ACQT_TADS_7 = 5'h14
)
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_n_i,
    // APB slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // Trigger sources
    input wire logic ccp_trig_i,
    input wire logic charge_time_unit_trig_i,
    input wire logic tmr1_trig_i,
    input wire logic rtc_trig_i,
    // Analog side
    input wire logic [11:0] conv_data_i,
    input wire logic [7:0] port_pins_i,
    output logic sample_o,
    output logic timer_reset_o,
    output logic done_irq_o
);
    import acs_pkg::*;
    // -------------------------------------------------------------------
    // State
    // -------------------------------------------------------------------
    acs_state_e state_r, state_nxt;
    logic en_r, en_nxt;
    logic go_r, go_nxt;
    logic done_r, done_nxt;
    logic [2:0] acqt_r, acqt_nxt;
    logic [2:0] adcs_r, adcs_nxt;
    logic [7:0] ansel_r, ansel_nxt;
    logic [3:0] ccp_mode_r, ccp_mode_nxt;
    logic ctt_en_r, ctt_en_nxt;
    logic [11:0] result_r, result_nxt;
    logic [4:0] tad_cnt_r, tad_cnt_nxt;
    logic delay_r, delay_nxt;
    logic sample_r, sample_nxt;
    logic trst_r, trst_nxt;
    logic [31:0] prdata_r, prdata_nxt;
    logic pready_r, pready_nxt;
    logic pslverr_r, pslverr_nxt;
    logic [3:0] trig_s1_r, trig_s2_r;
    logic [7:0] pin_s1_r, pin_s2_r;
    logic [3:0] trig_d_r;
    logic [3:0] trig_rise;
    logic any_trig;
    logic ccp_evt;
    logic wr, rd;
    logic [4:0] acq_tads;
    logic conv_abort;
    acs_tad_if tad ();

    acs_tad_gen u_tad
    (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .tad(tad)
    );

    // -------------------------------------------------------------------
    // Input synchronisers
    // -------------------------------------------------------------------
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            trig_s1_r <= 4'h0;
            trig_s2_r <= 4'h0;
            trig_d_r <= 4'h0;
            pin_s1_r <= 8'h00;
            pin_s2_r <= 8'h00;
        end
        else
        begin
            trig_s1_r <= {rtc_trig_i, tmr1_trig_i, charge_time_unit_trig_i, ccp_trig_i};
            trig_s2_r <= trig_s1_r;
            trig_d_r <= trig_s2_r;
            pin_s1_r <= port_pins_i;
            pin_s2_r <= pin_s1_r;
        end
    end

    // -------------------------------------------------------------------
    // Sequencer and registers
    // -------------------------------------------------------------------
    assign trig_rise = trig_s2_r & ~trig_d_r;
    assign ccp_evt = trig_rise[0] && (ccp_mode_r == CCP_TRIG_MODE);
    assign any_trig = ccp_evt || (trig_rise[1] && ctt_en_r) || trig_rise[2] || trig_rise[3];
    assign wr = psel_i && penable_i && pwrite_i && pready_r;
    assign rd = psel_i && !penable_i && !pwrite_i;

    // codes 010 and 000 fixed, others from parameters
    always_comb
    begin
        unique case (acqt_r)
            3'b001: acq_tads = ACQT_TADS_1;
            3'b010: acq_tads = ACQT_010_TADS;
            3'b011: acq_tads = ACQT_TADS_3;
            3'b100: acq_tads = ACQT_TADS_4;
            3'b101: acq_tads = ACQT_TADS_5;
            3'b110: acq_tads = ACQT_TADS_6;
            3'b111: acq_tads = ACQT_TADS_7;
            default: acq_tads = 5'h01;
        endcase
    end

    always_comb
    begin
        state_nxt = state_r;
        en_nxt = en_r;
        go_nxt = go_r;
        done_nxt = done_r;
        acqt_nxt = acqt_r;
        adcs_nxt = adcs_r;
        ansel_nxt = ansel_r;
        ccp_mode_nxt = ccp_mode_r;
        ctt_en_nxt = ctt_en_r;
        result_nxt = result_r;
        tad_cnt_nxt = tad_cnt_r;
        delay_nxt = 1'b0;
        conv_abort = 1'b0;
        trst_nxt = ccp_evt;
        if (wr)
        begin
            unique case (paddr_i)
                ADDR_CTRL:
                begin
                    en_nxt = pwdata_i[CTRL_EN_BIT];
                    go_nxt = pwdata_i[CTRL_GO_BIT] && pwdata_i[CTRL_EN_BIT];
                end
                ADDR_TIMING:
                begin
                    acqt_nxt = pwdata_i[TIM_ACQT_LSB +: 3];
                    adcs_nxt = pwdata_i[TIM_ADCS_LSB +: 3];
                end
                ADDR_RESULT: result_nxt = pwdata_i[11:0];
                ADDR_STATUS: done_nxt = pwdata_i[STAT_DONE_BIT];
                ADDR_ANSEL: ansel_nxt = pwdata_i[7:0];
                ADDR_TRIG:
                begin
                    ccp_mode_nxt = pwdata_i[TRIG_CCP_LSB +: 4];
                    ctt_en_nxt = pwdata_i[TRIG_CTT_BIT];
                end
                default: ;
            endcase
        end
        // trigger sets start; only when enabled
        if (any_trig && en_r)
            go_nxt = 1'b1;
        unique case (state_r)
            ST_SAMPLE:
            begin
                tad_cnt_nxt = 5'h00;
                if (go_r && en_r)
                begin
                    // no delay; one cycle later; programmed acquisition
                    state_nxt = (acqt_r == ACQT_RESET) ? ST_CONV : ST_ACQ;
                    delay_nxt = 1'b1;
                end
            end
            ST_ACQ:
            begin
                if (!go_nxt)
                    state_nxt = ST_SAMPLE;
                else if (tad.tick)
                begin
                    tad_cnt_nxt = tad_cnt_r + 5'h01;
                    if (tad_cnt_r + 5'h01 >= acq_tads)
                    begin
                        state_nxt = ST_CONV;
                        tad_cnt_nxt = 5'h00;
                    end
                end
            end
            ST_CONV:
            begin
                if (!go_nxt)
                begin
                    state_nxt = ST_WAIT;
                    tad_cnt_nxt = 5'h00;
                    delay_nxt = 1'b1;
                    conv_abort = 1'b1;
                end
                else if (tad.tick)
                begin
                    tad_cnt_nxt = tad_cnt_r + 5'h01;
                    if (tad_cnt_r + 5'h01 >= CONV_TADS)
                    begin
                        result_nxt = conv_data_i;
                        go_nxt = 1'b0;
                        done_nxt = 1'b1;
                        state_nxt = ST_WAIT;
                        tad_cnt_nxt = 5'h00;
                    end
                end
            end
            ST_WAIT:
            begin
                // two periods before resampling
                // A tick left over from the aborted period is not counted
                if (tad.tick && !delay_r)
                begin
                    tad_cnt_nxt = tad_cnt_r + 5'h01;
                    if (tad_cnt_r + 5'h01 >= WAIT_TADS)
                        state_nxt = ST_SAMPLE;
                end
            end
        endcase
        if (!en_nxt)
            go_nxt = 1'b0;
        sample_nxt = (state_nxt == ST_SAMPLE) || (state_nxt == ST_ACQ);
        prdata_nxt = 32'h0000_0000;
        pslverr_nxt = 1'b0;
        if (rd)
        begin
            unique case (paddr_i)
                ADDR_CTRL: prdata_nxt = {30'h0, go_r, en_r};
                ADDR_TIMING: prdata_nxt = {26'h0, acqt_r, adcs_r};
                ADDR_RESULT: prdata_nxt = {20'h0, result_r};
                ADDR_STATUS: prdata_nxt = {31'h0, done_r};
                ADDR_ANSEL: prdata_nxt = {24'h0, ansel_r};
                ADDR_PORT: prdata_nxt = {24'h0, pin_s2_r & ~ansel_r};
                ADDR_TRIG: prdata_nxt = {27'h0, ctt_en_r, ccp_mode_r};
                default: pslverr_nxt = 1'b1;
            endcase
        end
        else
        begin
            prdata_nxt = prdata_r;
            pslverr_nxt = pslverr_r && penable_i;
        end
        if (psel_i && !penable_i && pwrite_i)
            pslverr_nxt = !(paddr_i <= ADDR_TRIG && paddr_i[1:0] == 2'b00 && paddr_i != ADDR_PORT);
        pready_nxt = psel_i && !penable_i;
    end

    // reset restores every field and aborts
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            state_r <= ST_SAMPLE;
            en_r <= 1'b0;
            go_r <= 1'b0;
            done_r <= 1'b0;
            acqt_r <= ACQT_RESET;
            adcs_r <= ADCS_RESET;
            ansel_r <= ANSEL_RESET;
            ccp_mode_r <= 4'h0;
            ctt_en_r <= 1'b0;
            result_r <= RESULT_RESET;
            tad_cnt_r <= 5'h00;
            delay_r <= 1'b0;
            sample_r <= 1'b1;
            trst_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            en_r <= en_nxt;
            go_r <= go_nxt;
            done_r <= done_nxt;
            acqt_r <= acqt_nxt;
            adcs_r <= adcs_nxt;
            ansel_r <= ansel_nxt;
            ccp_mode_r <= ccp_mode_nxt;
            ctt_en_r <= ctt_en_nxt;
            result_r <= result_nxt;
            tad_cnt_r <= tad_cnt_nxt;
            delay_r <= delay_nxt;
            sample_r <= sample_nxt;
            trst_r <= trst_nxt;
            prdata_r <= prdata_nxt;
            pready_r <= pready_nxt;
            pslverr_r <= pslverr_nxt;
        end
    end

    assign tad.clk_sel = adcs_r;
    // Restart the divider on entry so every wait gets whole bit periods
    assign tad.run = (state_r != ST_SAMPLE) && !delay_r;
    assign prdata_o = prdata_r;
    assign pready_o = pready_r;
    assign pslverr_o = pslverr_r;
    assign sample_o = sample_r;
    assign timer_reset_o = trst_r;
    assign done_irq_o = done_r;

    // -------------------------------------------------------------------
    // Assertions
    // -------------------------------------------------------------------
    a_disabled_no_go: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        !en_r |-> !go_r) else $error("start flag set while disabled");
    a_conv_no_sample: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        state_r == ST_CONV |-> !sample_r) else $error("sampling during conversion");
    a_done_clears_go: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        $rose(done_r) && state_r == ST_WAIT |-> !go_r) else $error("done without clearing start");
    a_abort_keeps_res: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        conv_abort && !(wr && paddr_i == ADDR_RESULT) |=> $stable(result_r))
        else $error("abort changed result");
    a_zero_acq_direct: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        state_r == ST_SAMPLE && go_r && en_r && acqt_r == ACQT_RESET |=> state_r == ST_CONV)
        else $error("no direct conversion");
    a_ccp_timer_rst: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        ccp_evt |=> timer_reset_o) else $error("timer not reset");
    a_go_held: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        state_r == ST_ACQ && go_nxt |=> go_r) else $error("start flag dropped");
    a_wait_leaves: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        state_r == ST_WAIT && tad.tick && tad_cnt_r == 5'h01 |=> state_r == ST_SAMPLE)
        else $error("wait length wrong");
    c_conv_done: cover property (@(posedge clk_i) $rose(done_r));
    c_abort: cover property (@(posedge clk_i) state_r == ST_CONV && !go_nxt);
    c_trig_start: cover property (@(posedge clk_i) any_trig && en_r);
endmodule // acs_seq

/* testbench/acs_analog_src.sv */
`timescale 1ns/100ps
// ---------------------------------------------------------------
// Analog source on the selected channel
// ---------------------------------------------------------------
module acs_analog_src
(
    // Clock
    input wire logic clk_i,
    // Converter side
    input wire logic sample_i,
    input wire logic [11:0] level_i,
    output logic [11:0] conv_data_o
);
    // held charge ignores the pin once the switch opens
    always_ff @(posedge clk_i)
    begin
        if (sample_i)
        begin
            conv_data_o <= level_i;
        end
    end
endmodule // acs_analog_src

/* testbench/testbench.sv */
`timescale 1ns/100ps
module testbench;
    import acs_pkg::*;
    typedef struct {logic [2:0] adcs; logic [2:0] acqt; int div; int acq; logic [11:0] data;} acs_row_s;
    // ---------------------------------------------------------------
    // Signals
    // ---------------------------------------------------------------
    logic clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, sample, tmr_rst, done;
    logic [3:0] trig = 4'h0;
    logic [11:0] level = 12'h000;
    logic [11:0] conv_data;
    logic [7:0] pins = 8'hA5;
    logic [31:0] r;
    logic e;
    int failures = 0;
    int tests_run = 0;
    int tmr_cnt = 0;
    int n;
    // every row uses a legal bit period setting
    // Clock select and acquisition code in each row, with bit period and acquisition length
    acs_row_s rows [8] = '{
        '{3'h0, 3'h0, 2, 0, 12'h0A5}, '{3'h4, 3'h1, 4, 2, 12'h5A0}, '{3'h1, 3'h2, 8, 4, 12'hFFF},
        '{3'h5, 3'h3, 16, 6, 12'h001}, '{3'h2, 3'h4, 32, 8, 12'h800}, '{3'h6, 3'h5, 64, 12, 12'h7FF},
        '{3'h3, 3'h6, 40, 16, 12'h3C3}, '{3'h7, 3'h7, 40, 20, 12'hC3C}};

    always #50 clk_i = ~clk_i;

    acs_seq dut_u (.clk_i(clk_i), .reset_n_i(reset_n_i),
        .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .ccp_trig_i(trig[0]),
        .charge_time_unit_trig_i(trig[1]), .tmr1_trig_i(trig[2]), .rtc_trig_i(trig[3]), .conv_data_i(conv_data),
        .port_pins_i(pins), .sample_o(sample), .timer_reset_o(tmr_rst), .done_irq_o(done));

    acs_analog_src src_u (.clk_i(clk_i), .sample_i(sample), .level_i(level), .conv_data_o(conv_data));

    always @(negedge clk_i)
    begin
        if (tmr_rst === 1'b1)
        begin
            tmr_cnt++;
        end
    end
    // ---------------------------------------------------------------
    // Tasks
    // ---------------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            failures++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Cycle counts are taken at negedges, so allow a little slack
    function automatic logic [31:0] near(input int seen, input int exp);
        return ((seen >= exp - 3) && (seen <= exp + 3)) ? exp : seen;
    endfunction

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_i);
        penable <= 1'b1;
        k = 0;
        do
        begin
            @(posedge clk_i);
            k++;
        end
        while (pready !== 1'b1 && k < 20);
        r = prdata;
        e = pslverr;
        chk(32'(k < 20), 32'h1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_i);
    endtask

    // Mode 0: sampling, 1: converting, 2: converting or waiting
    task automatic span(input int mode, output int c);
        c = 0;
        @(negedge clk_i);
        while (c < 3000 && ((mode == 0) ? sample === 1'b1 : (sample === 1'b0 && (mode == 2 || done !== 1'b1))))
        begin
            @(negedge clk_i);
            c++;
        end
        @(posedge clk_i);
    endtask

    task automatic pulse(input int t);
        trig[t] <= 1'b1;
        repeat (3) @(posedge clk_i);
        trig[t] <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic results();
        $display("failures=%0d tests_run=%0d", failures, tests_run);
        if (failures == 0 && tests_run > 0)
        begin
            $display("[ PASS ]");
        end
        else
        begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // ---------------------------------------------------------------
    // Watchdog
    // ---------------------------------------------------------------
    initial
    begin
        repeat (40000) @(posedge clk_i);
        failures++;
        results();
    end
    // ---------------------------------------------------------------
    // Main sequence
    // ---------------------------------------------------------------
    initial
    begin
        repeat (16) @(posedge clk_i);
        reset_n_i <= 1'b1;
        @(posedge clk_i);
        apb(1'b0, ADDR_TIMING, 32'h0);
        chk(r, 32'h0);
        apb(1'b0, ADDR_ANSEL, 32'h0);
        chk(r, 32'hFF);
        apb(1'b0, ADDR_PORT, 32'h0);
        chk(r, 32'h0);
        apb(1'b1, ADDR_ANSEL, 32'h0F);
        apb(1'b0, ADDR_PORT, 32'h0);
        chk(r, 32'hA0);
        pins <= 8'h5A;
        repeat (3) @(posedge clk_i);
        apb(1'b0, ADDR_PORT, 32'h0);
        chk(r, 32'h50);
        apb(1'b1, ADDR_PORT, 32'h0);
        chk({31'h0, e}, 32'h1);
        apb(1'b0, 8'h1C, 32'h0);
        chk({31'h0, e}, 32'h1);
        // enable set by this write, before the loop
        apb(1'b1, ADDR_CTRL, 32'h1);
        foreach (rows[i])
        begin
            level <= rows[i].data;
            apb(1'b1, ADDR_TIMING, {26'h0, rows[i].acqt, rows[i].adcs});
            apb(1'b1, ADDR_STATUS, 32'h0);
            apb(1'b1, ADDR_CTRL, 32'h3);
            span(0, n);
            chk(near(n, rows[i].acq * rows[i].div), rows[i].acq * rows[i].div);
            span(1, n);
            chk(near(n, 14 * rows[i].div), 14 * rows[i].div);
            chk({31'h0, done}, 32'h1);
            span(2, n);
            chk(near(n, 2 * rows[i].div), 2 * rows[i].div);
            apb(1'b0, ADDR_CTRL, 32'h0);
            chk(r, 32'h1);
            apb(1'b0, ADDR_RESULT, 32'h0);
            chk(r, {20'h0, rows[i].data});
        end
        // Abort in mid conversion keeps the software-written result
        apb(1'b1, ADDR_RESULT, 32'h123);
        apb(1'b1, ADDR_TIMING, 32'h16);
        apb(1'b1, ADDR_STATUS, 32'h0);
        apb(1'b1, ADDR_CTRL, 32'h3);
        apb(1'b0, ADDR_CTRL, 32'h0);
        chk(r, 32'h3);
        span(0, n);
        repeat (100) @(posedge clk_i);
        apb(1'b0, ADDR_CTRL, 32'h0);
        chk(r, 32'h3);
        apb(1'b1, ADDR_CTRL, 32'h1);
        span(2, n);
        chk(near(n, 128), 128);
        chk({31'h0, done}, 32'h0);
        apb(1'b0, ADDR_RESULT, 32'h0);
        chk(r, 32'h123);
        apb(1'b1, ADDR_CTRL, 32'h0);
        apb(1'b1, ADDR_CTRL, 32'h2);
        apb(1'b0, ADDR_CTRL, 32'h0);
        chk(r, 32'h0);
        apb(1'b1, ADDR_CTRL, 32'h1);
        apb(1'b1, ADDR_TIMING, 32'h0);
        apb(1'b1, ADDR_TRIG, {27'h0, 1'b1, CCP_TRIG_MODE});
        for (int t = 0; t < 4; t++)
        begin
            apb(1'b1, ADDR_STATUS, 32'h0);
            pulse(t);
            apb(1'b0, ADDR_CTRL, 32'h0);
            chk(r, 32'h3);
            span(2, n);
            chk({31'h0, done}, 32'h1);
        end
        chk(tmr_cnt, 1);
        apb(1'b1, ADDR_CTRL, 32'h0);
        apb(1'b1, ADDR_STATUS, 32'h0);
        for (int t = 0; t < 4; t++)
        begin
            pulse(t);
        end
        repeat (40) @(posedge clk_i);
        apb(1'b0, ADDR_CTRL, 32'h0);
        chk(r, 32'h0);
        chk({30'h0, sample, done}, 32'h2);
        chk(tmr_cnt, 2);
        // Reset in mid conversion
        apb(1'b1, ADDR_TIMING, 32'h16);
        apb(1'b1, ADDR_CTRL, 32'h1);
        apb(1'b1, ADDR_CTRL, 32'h3);
        repeat (300) @(posedge clk_i);
        reset_n_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        reset_n_i <= 1'b1;
        @(negedge clk_i);
        chk({30'h0, sample, done}, 32'h2);
        @(posedge clk_i);
        apb(1'b0, ADDR_CTRL, 32'h0);
        chk(r, 32'h0);
        apb(1'b0, ADDR_TIMING, 32'h0);
        chk(r, 32'h0);
        results();
    end
endmodule // testbench
